// *** core/mcd_params.svh ***
// Constants of the dual-set modem clock divider: offsets, field positions,
// reset values. Included by the package and the core; definitions only.
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

`define MCD_OFF_CLOCK_A 8'h07
`define MCD_OFF_WORD_B_HIGH 8'h08
`define MCD_OFF_WORD_B_MID 8'h09
`define MCD_OFF_WORD_B_LOW 8'h0a
`define MCD_OFF_CLOCK_B 8'h0b

`define MCD_REF_DIV_MSB 7
`define MCD_REF_DIV_LSB 5
`define MCD_PRE1_MSB 4
`define MCD_PRE1_LSB 2
`define MCD_PRE2_MSB 1
`define MCD_PRE2_LSB 0
`define MCD_WORD_LOW_MSB 7
`define MCD_WORD_LOW_LSB 1
`define MCD_DITHER_BIT 0

`define MCD_RST_CLOCK 8'h50
`define MCD_RST_WORD_B_HIGH 8'h83
`define MCD_RST_WORD_B_MID 8'hbd
`define MCD_RST_WORD_B_LOW 8'hf9

`define MCD_BAUD_DIV 3'h7
`define MCD_READ_NONE 8'h00

`endif

// *** core/mcd_pkg.sv ***
// Types of the dual-set modem clock divider.
// Assumes mcd_params.svh is on the include path.
`include "mcd_params.svh"

package mcd_pkg;

   typedef struct packed {
      logic [2:0] ref_div;
      logic [2:0] prescale_first;
      logic [1:0] prescale_second;
   } mcd_clk_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mcd_bus_req_t;

   typedef struct packed {
      logic ref_tick;
      logic modem_tick;
      logic baud_tick;
   } mcd_ticks_t;

endpackage

// *** core/mcd_top.sv ***
// Dual-set modem clock divider: configuration registers and the
// reference, modem and baud enable pulses derived from the crystal clock.
// The enables are one-cycle pulses, not divided square clocks.
// Assumes sys_clk_i is the crystal clock, set_sel_i comes from logic on
// the same clock, and the master never raises both strobes at once.
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire mcd_pkg::mcd_bus_req_t bus_req_i,
   output logic [7:0] rd_data_o,
   // Set choice
   input wire logic set_sel_i,
   // Clock enables and active settings
   output mcd_pkg::mcd_ticks_t ticks_o,
   output mcd_pkg::mcd_clk_cfg_t active_cfg_o,
   output logic active_set_o,
   output logic [22:0] synth_word_b_o,
   output logic fractional_noise_enable_b_o
);
   import mcd_pkg::*;

   // Register file
   logic [7:0] clock_divider_set_a_q;
   logic [7:0] clock_divider_set_b_q;
   logic [7:0] synth_word_b_high_q;
   logic [7:0] synth_word_b_mid_q;
   logic [7:0] synth_word_b_low_dither_q;

   // Read path
   logic [7:0] rd_data_q;
   logic [4:0] wr_sel;
   logic [4:0] rd_sel;
   logic [7:0] rd_value;

   // Active settings
   mcd_clk_cfg_t active_cfg_q;
   mcd_clk_cfg_t active_cfg_d;
   logic active_set_q;
   logic cfg_change;

   // Dividers
   logic [2:0] ref_cnt_q;
   logic ref_tick_q;
   logic ref_wrap;
   logic [10:0] half_acc_q;
   logic [10:0] half_sum;
   logic [10:0] half_total;
   logic modem_wrap;
   logic modem_tick_q;
   logic [2:0] baud_cnt_q;
   logic baud_tick_q;

   // Field split shared by both sets
   function automatic mcd_clk_cfg_t split_cfg(input logic [7:0] raw);
      mcd_clk_cfg_t c;
      c.ref_div = raw[`MCD_REF_DIV_MSB:`MCD_REF_DIV_LSB];
      c.prescale_first = raw[`MCD_PRE1_MSB:`MCD_PRE1_LSB];
      c.prescale_second = raw[`MCD_PRE2_MSB:`MCD_PRE2_LSB];
      return c;
   endfunction

   // First prescaler ratio in half steps
   function automatic logic [7:0] prescale_first_half(input logic [2:0] code);
      logic [7:0] h;
      h = 8'h05;
      case (code)
         3'h0: h = 8'h05;
         3'h1: h = 8'h06;
         3'h2: h = 8'h08;
         3'h3: h = 8'h0f;
         3'h4: h = 8'h19;
         3'h5: h = 8'h50;
         3'h6: h = 8'h60;
         3'h7: h = 8'h80;
         default: h = 8'h05;
      endcase
      return h;
   endfunction

   // Register select, one bit per mapped offset
   function automatic logic [4:0] decode_addr(input logic [7:0] addr);
      logic [4:0] sel;
      sel = 5'h00;
      case (addr)
         `MCD_OFF_CLOCK_A: sel = 5'h01;
         `MCD_OFF_WORD_B_HIGH: sel = 5'h02;
         `MCD_OFF_WORD_B_MID: sel = 5'h04;
         `MCD_OFF_WORD_B_LOW: sel = 5'h08;
         `MCD_OFF_CLOCK_B: sel = 5'h10;
         default: sel = 5'h00;
      endcase
      return sel;
   endfunction

   // Reference count limit; unsupported code 0 runs as code 1
   function automatic logic [2:0] ref_limit(input logic [2:0] code);
      logic [2:0] lim;
      lim = code;
      if (code == 3'h0) begin
         lim = 3'h1;
      end
      return lim;
   endfunction

   // Strobe decode; read data only for a mapped read
   always_comb begin
      wr_sel = bus_req_i.wr ? decode_addr(bus_req_i.addr) : 5'h00;
      rd_sel = bus_req_i.rd ? decode_addr(bus_req_i.addr) : 5'h00;
      rd_value = `MCD_READ_NONE;
      if (rd_sel != 5'h00) begin
         rd_value = ({8{rd_sel[0]}} & clock_divider_set_a_q)
                  | ({8{rd_sel[1]}} & synth_word_b_high_q)
                  | ({8{rd_sel[2]}} & synth_word_b_mid_q)
                  | ({8{rd_sel[3]}} & synth_word_b_low_dither_q)
                  | ({8{rd_sel[4]}} & clock_divider_set_b_q);
      end
   end

   // Clock set A
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clock_divider_set_a_q <= `MCD_RST_CLOCK;
      end else if (wr_sel[0]) begin
         clock_divider_set_a_q <= bus_req_i.wdata;
      end
   end

   // Clock set B
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clock_divider_set_b_q <= `MCD_RST_CLOCK;
      end else if (wr_sel[4]) begin
         clock_divider_set_b_q <= bus_req_i.wdata;
      end
   end

   // Word B, high byte
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         synth_word_b_high_q <= `MCD_RST_WORD_B_HIGH;
      end else if (wr_sel[1]) begin
         synth_word_b_high_q <= bus_req_i.wdata;
      end
   end

   // Word B, middle byte
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         synth_word_b_mid_q <= `MCD_RST_WORD_B_MID;
      end else if (wr_sel[2]) begin
         synth_word_b_mid_q <= bus_req_i.wdata;
      end
   end

   // Word B, low seven bits and dither enable
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         synth_word_b_low_dither_q <= `MCD_RST_WORD_B_LOW;
      end else if (wr_sel[3]) begin
         synth_word_b_low_dither_q <= bus_req_i.wdata;
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_q <= `MCD_READ_NONE;
      end else begin
         rd_data_q <= rd_value;
      end
   end

   // Active set choice
   always_comb begin
      active_cfg_d = set_sel_i ? split_cfg(clock_divider_set_b_q)
                               : split_cfg(clock_divider_set_a_q);
      cfg_change = (active_cfg_d != active_cfg_q) || (set_sel_i != active_set_q);
   end

   // Active settings, restart point of every divider
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active_cfg_q <= mcd_clk_cfg_t'(`MCD_RST_CLOCK);
      end else begin
         active_cfg_q <= active_cfg_d;
      end
   end

   // Registered copy of the select
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active_set_q <= 1'b0;
      end else begin
         active_set_q <= set_sel_i;
      end
   end

   // Reference divider
   always_comb begin
      ref_wrap = ref_cnt_q >= ref_limit(active_cfg_q.ref_div);
   end

   // Count restarts on a change or at the limit
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ref_cnt_q <= 3'h0;
      end else if (cfg_change || ref_wrap) begin
         ref_cnt_q <= 3'h0;
      end else begin
         ref_cnt_q <= ref_cnt_q + 3'h1;
      end
   end

   // Pulse suppressed in the restart cycle
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ref_tick_q <= 1'b0;
      end else begin
         ref_tick_q <= ref_wrap && !cfg_change;
      end
   end

   // Modem divider in half steps, so fractional ratios average exactly
   always_comb begin
      half_total = {3'h0, prescale_first_half(active_cfg_q.prescale_first)}
                   << active_cfg_q.prescale_second;
      half_sum = half_acc_q + 11'h002;
      modem_wrap = ref_tick_q && (half_sum >= half_total);
   end

   // Remainder keeps the half step of fractional ratios
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         half_acc_q <= 11'h000;
      end else if (cfg_change) begin
         half_acc_q <= 11'h000;
      end else if (modem_wrap) begin
         half_acc_q <= half_sum - half_total;
      end else if (ref_tick_q) begin
         half_acc_q <= half_sum;
      end
   end

   // Pulse suppressed in the restart cycle
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         modem_tick_q <= 1'b0;
      end else begin
         modem_tick_q <= modem_wrap && !cfg_change;
      end
   end

   // Baud divider, one pulse per eight modem pulses
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         baud_cnt_q <= 3'h0;
      end else if (cfg_change) begin
         baud_cnt_q <= 3'h0;
      end else if (modem_tick_q) begin
         baud_cnt_q <= baud_cnt_q + 3'h1;
      end
   end

   // Pulse on the eighth modem pulse, none in a restart
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         baud_tick_q <= 1'b0;
      end else begin
         baud_tick_q <= modem_tick_q && (baud_cnt_q == `MCD_BAUD_DIV)
                        && !cfg_change;
      end
   end

   // Outputs, each straight from a flop
   assign rd_data_o = rd_data_q;
   assign ticks_o = '{ref_tick: ref_tick_q, modem_tick: modem_tick_q, baud_tick: baud_tick_q};
   assign active_cfg_o = active_cfg_q;
   assign active_set_o = active_set_q;
   assign synth_word_b_o = {synth_word_b_high_q, synth_word_b_mid_q,
      synth_word_b_low_dither_q[`MCD_WORD_LOW_MSB:`MCD_WORD_LOW_LSB]};
   assign fractional_noise_enable_b_o = synth_word_b_low_dither_q[`MCD_DITHER_BIT];

endmodule // mcd_top

// *** tb/mcd_asserts.sv ***
// Port checker of the dual-set modem clock divider.
// Assumes it is bound onto mcd_top and shares its single clock.
`timescale 1ns/1ps
module mcd_asserts (
   // Clock, reset, register port, select
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire mcd_pkg::mcd_bus_req_t bus_req_i,
   input wire logic [7:0] rd_data_o,
   input wire logic set_sel_i,
   // Enables and active settings
   input wire mcd_pkg::mcd_ticks_t ticks_o,
   input wire mcd_pkg::mcd_clk_cfg_t active_cfg_o,
   input wire logic active_set_o,
   input wire logic [22:0] synth_word_b_o,
   input wire logic fractional_noise_enable_b_o
);
   import mcd_pkg::*;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   a_rd_idle_zero: assert property (!$past(bus_req_i.rd) |-> rd_data_o == 8'h00)
      else $error("read data outside its slot");
   a_ref_single: assert property (ticks_o.ref_tick |=> !ticks_o.ref_tick)
      else $error("reference tick longer than one cycle");
   a_modem_after_ref: assert property (ticks_o.modem_tick |-> $past(ticks_o.ref_tick))
      else $error("modem tick without reference tick");
   a_baud_after_modem: assert property (ticks_o.baud_tick |-> $past(ticks_o.modem_tick))
      else $error("baud tick without modem tick");
   a_modem_min_gap: assert property (ticks_o.modem_tick |=> !ticks_o.modem_tick [*3])
      else $error("modem ticks too close");
   a_baud_min_gap: assert property (ticks_o.baud_tick |=> !ticks_o.baud_tick [*8])
      else $error("baud ticks too close");
   a_set_follow: assert property (active_set_o == $past(set_sel_i))
      else $error("active set does not follow select");
   a_word_hold: assert property (!$past(bus_req_i.wr) |->
      $stable(synth_word_b_o) && $stable(fractional_noise_enable_b_o))
      else $error("word B moved without a write");
   a_cfg_hold: assert property (!$past(bus_req_i.wr) && !$past(bus_req_i.wr, 2) &&
      !$past(bus_req_i.wr, 3) && $stable(set_sel_i) && $past(set_sel_i) == $past(set_sel_i, 3)
      && $past(set_sel_i) == $past(set_sel_i, 2) |-> $stable(active_cfg_o))
      else $error("active setting moved without cause");
   c_baud: cover property (ticks_o.baud_tick);
   c_set_b: cover property ($rose(active_set_o));
   c_read: cover property (bus_req_i.rd ##1 rd_data_o != 8'h00);
endmodule // mcd_asserts
bind mcd_top mcd_asserts u_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .bus_req_i(bus_req_i), .rd_data_o(rd_data_o), .set_sel_i(set_sel_i), .ticks_o(ticks_o),
   .active_cfg_o(active_cfg_o), .active_set_o(active_set_o), .synth_word_b_o(synth_word_b_o),
   .fractional_noise_enable_b_o(fractional_noise_enable_b_o));

// *** tb/mcd_host.sv ***
// Controller model driving the divider's register port.
// Assumes one clock shared with the divider.
`timescale 1ns/1ps
module mcd_host (
   // Clock
   input wire logic sys_clk_i,
   // Register port
   output mcd_pkg::mcd_bus_req_t req_o,
   input wire logic [7:0] rd_data_i
);
   import mcd_pkg::*;
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_i);
      req_o.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_i);
      req_o.rd <= 1'b0;
      @(negedge sys_clk_i);
      d = rd_data_i;
   endtask
endmodule // mcd_host

// *** tb/mcd_top_tb_top.sv ***
// Self-checking bench of the dual-set modem clock divider.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
module mcd_top_tb_top;
   import mcd_pkg::*;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic set_sel_i = 1'b0;
   mcd_bus_req_t req;
   mcd_ticks_t ticks;
   mcd_clk_cfg_t act_cfg;
   logic [7:0] rd_data, rv;
   logic [22:0] word_b;
   logic act_set, dith;
   int n_errors = 0;
   int check_count = 0;
   int c;
   int r2 [8] = '{5, 6, 8, 15, 25, 80, 96, 128};
   always #25 sys_clk_i = ~sys_clk_i;
   mcd_host host (.sys_clk_i(sys_clk_i), .req_o(req), .rd_data_i(rd_data));
   mcd_top dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bus_req_i(req),
      .rd_data_o(rd_data), .set_sel_i(set_sel_i), .ticks_o(ticks), .active_cfg_o(act_cfg),
      .active_set_o(act_set), .synth_word_b_o(word_b), .fractional_noise_enable_b_o(dith));
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Clocks spanned by n tick intervals of one enable
   task automatic span(int b, int n, output int clk_n);
      int seen;
      clk_n = 0;
      seen = -1;
      for (int i = 0; i < 3000 && seen < n; i++) begin
         @(negedge sys_clk_i);
         if (seen >= 0) clk_n++;
         if (ticks[b] === 1'b1) seen++;
      end
      if (seen < n) begin
         n_errors++;
         $display("ERROR tick wait expected %0d seen %0d", n, seen);
         conclude();
      end
   endtask
   task automatic setcfg(logic sel, logic [7:0] cfg);
      @(posedge sys_clk_i) set_sel_i <= sel;
      host.wr(sel ? 8'h0b : 8'h07, cfg);
      repeat (3) @(negedge sys_clk_i);
      chk("active cfg", cfg, act_cfg);
      chk("active set", sel, act_set);
   endtask
   task automatic t_reset();
      logic [7:0] exp [5] = '{8'h50, 8'h83, 8'hbd, 8'hf9, 8'h50};
      for (int a = 7; a < 12; a++) begin
         host.rd(a[7:0], rv);
         chk("reset reg", exp[a-7], rv);
      end
      host.rd(8'h3f, rv);
      chk("unmapped read", 8'h00, rv);
      chk("reset word", {8'h83, 8'hbd, 7'h7c}, word_b);
      chk("reset dither", 1'b1, dith);
      chk("reset cfg", 8'h50, act_cfg);
      $display("test reset done");
   endtask
   task automatic t_word();
      host.wr(8'h08, 8'ha5);
      host.wr(8'h09, 8'h3c);
      host.wr(8'h0a, 8'h0e);
      host.wr(8'h3f, 8'hff);
      host.rd(8'h0a, rv);
      chk("low reg", 8'h0e, rv);
      host.rd(8'h3f, rv);
      chk("unmapped write", 8'h00, rv);
      chk("word b", {8'ha5, 8'h3c, 7'h07}, word_b);
      chk("dither", 1'b0, dith);
      $display("test word done");
   endtask
   task automatic t_ref();
      setcfg(1'b0, {3'h0, 3'h1, 2'h0});
      span(2, 4, c);
      chk("ref span code 0", 8, c);
      for (int r = 1; r < 8; r++) begin
         setcfg(1'b0, {r[2:0], 3'h1, 2'h0});
         span(2, 4, c);
         chk("ref span", 4 * (r + 1), c);
      end
      $display("test ref done");
   endtask
   task automatic t_pre1();
      for (int p = 0; p < 8; p++) begin
         setcfg(1'b1, {3'h1, p[2:0], 2'h0});
         span(1, 2, c);
         chk("modem span", 2 * r2[p], c);
      end
      $display("test first prescaler done");
   endtask
   task automatic t_pre2();
      @(posedge sys_clk_i) set_sel_i <= 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk("set a kept", {3'h7, 3'h1, 2'h0}, act_cfg);
      for (int q = 0; q < 4; q++) begin
         setcfg(1'b0, {3'h1, 3'h0, q[1:0]});
         span(1, 2, c);
         chk("modem span", 10 << q, c);
         span(0, 1, c);
         chk("baud span", 40 << q, c);
      end
      $display("test second prescaler done");
   endtask
   task automatic t_rst2();
      host.wr(8'h08, 8'h00);
      host.wr(8'h0b, 8'h00);
      @(posedge sys_clk_i) arst_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      host.rd(8'h0b, rv);
      chk("reset reg b", 8'h50, rv);
      chk("reset word again", {8'h83, 8'hbd, 7'h7c}, word_b);
      chk("reset dither again", 1'b1, dith);
      chk("reset set", 1'b0, act_set);
      span(2, 4, c);
      chk("reset ref span", 12, c);
      $display("test second reset done");
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_word();
      t_ref();
      t_pre1();
      t_pre2();
      t_rst2();
      conclude();
   end
endmodule // mcd_top_tb_top
